// ### common/aisq_pkg.sv
package aisq_pkg;

   // ==========================================================
   // Sizes
   // ==========================================================
   localparam int NCH = 8;
   localparam int CHW = 3;
   localparam int SW = 16;
   localparam int MAW = 9;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int CLK_NS = 10;
   localparam int T_SLOW_NS = 1000000;
   localparam int T_FAST_NS = 250000;
   localparam int SLOW_CYC = T_SLOW_NS / CLK_NS;
   localparam int FAST_CYC = T_FAST_NS / CLK_NS;

   // ==========================================================
   // Word indices; byte address is four times the index
   // ==========================================================
   localparam logic [9:0] CYC_BASE = 10'h000;
   localparam logic [9:0] CFG_BASE = 10'h040;
   localparam logic [9:0] CYC_HOLD_IDX = 10'h000;
   localparam logic [9:0] CYC_VAL_IDX = 10'h001;
   localparam logic [9:0] CYC_FLAG_IDX = 10'h009;
   localparam logic [9:0] CFG_EN_IDX = 10'h000;
   localparam logic [9:0] CFG_RNG_IDX = 10'h001;
   localparam logic [9:0] CFG_AVG_IDX = 10'h002;
   localparam logic [9:0] CFG_MODE_IDX = 10'h012;

   // ==========================================================
   // Fields and reset values
   // ==========================================================
   localparam int FLAG_ALARM_BIT = 15;
   localparam int MODE_FAST_BIT = 0;
   localparam logic [7:0] EN_RST = 8'h00;
   localparam logic [23:0] RNG_RST = 24'h000000;
   localparam logic [23:0] AVG_RST = 24'h000000;
   localparam logic MODE_RST = 1'b0;

   // ==========================================================
   // Conversion limits at 4,000 resolution
   // ==========================================================
   localparam logic signed [15:0] BIP_HI_4K = 16'sh0898;
   localparam logic signed [15:0] BIP_LO_4K = 16'shf768;
   localparam logic signed [15:0] UNI_HI_4K = 16'sh1004;
   localparam logic signed [15:0] UNI_LO_4K = 16'shff9c;
   localparam logic signed [15:0] BRK_LIM = 16'shfe0c;

   typedef enum logic [2:0] {
      RNG_BIP10 = 3'h0,
      RNG_U10 = 3'h1,
      RNG_U1_5 = 3'h2,
      RNG_U5 = 3'h3,
      RNG_MA = 3'h4
   } aisq_rng_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_PRIME = 3'h1,
      ST_WR = 3'h2,
      ST_SUM = 3'h3,
      ST_DONE = 3'h4
   } aisq_st_t;

endpackage

// ### logic/aisq_hist_mem.sv
`timescale 1ns/100ps
module aisq_hist_mem (
   // Clock and enable
   input wire logic clk_i,
   input wire logic ce_i,
   // Access port
   input wire logic we_i,
   input wire logic [aisq_pkg::MAW-1:0] addr_i,
   input wire logic [aisq_pkg::SW-1:0] wdata_i,
   output logic [aisq_pkg::SW-1:0] rdata_o
);

   logic [aisq_pkg::SW-1:0] mem_q [1 << aisq_pkg::MAW];

   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         if (we_i) begin
            mem_q[addr_i] <= wdata_i;
         end
         rdata_o <= mem_q[addr_i];
      end
   end

endmodule

// ### logic/aisq_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Keep last n results per channel, report mean; n is 1..64.
// - With peak hold set, report largest value since hold was set.
// - Detected broken line sets that channel's flag in status word.
// - Break detection only on 1-5 V and 4-20 mA ranges, no signal.
// - Per-point period is 1 ms or 250 us, one conversion each.
// - One mode bit selects 8,000 resolution and 250 us together.
// - Out-of-range input saturates at the range maximum or minimum.
// - Every reported result is a 16-bit binary word.
// - Bipolar at 4,000 spans F768 to 0898 two's complement.
// - Values, break and alarm flags go out in the 10-word area.
// - Each channel has its own range selection.
// - New value is visible only after at least one refresh.
module aisq_top #(
   parameter int SLOW_CYC = aisq_pkg::SLOW_CYC,
   parameter int FAST_CYC = aisq_pkg::FAST_CYC
) (
   // Clock, enable and reset
   input wire logic clk_i,
   input wire logic ce_i,
   input wire logic rst_n_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Converter request
   output logic adc_req_o,
   output logic [2:0] adc_ch_o,
   // Converter result
   input wire logic adc_valid_i,
   input wire logic [2:0] adc_ch_i,
   input wire logic [15:0] adc_data_i,
   output logic adc_ready_o
);

   // =============================================================
   // State
   // =============================================================
   typedef struct packed {
      logic [7:0] en;
      logic [23:0] rng;
      logic [23:0] avg;
      logic fast;
      logic [7:0] hold;
      logic [7:0][15:0] val;
      logic [7:0][15:0] peak;
      logic [7:0] pk_ok;
      logic [7:0] brk;
      logic [7:0] primed;
      logic [7:0][5:0] wp;
      logic [16:0] tmr;
      logic [2:0] last;
      logic req;
      logic [2:0] req_ch;
      logic [1:0][18:0] fifo;
      logic [1:0] cnt;
      logic rdy;
      aisq_pkg::aisq_st_t st;
      logic [2:0] ch;
      logic [15:0] smp;
      logic [6:0] i;
      logic rd_v;
      logic [21:0] acc;
      logic ack;
      logic [31:0] dat;
   } aisq_state_t;

   aisq_state_t q;
   aisq_state_t d;
   logic mem_we;
   logic [8:0] mem_addr;
   logic [15:0] mem_rd;

   // =============================================================
   // Helpers
   // =============================================================
   function automatic logic [2:0] rng_of(input logic [23:0] r,
                                         input logic [2:0] c);
      return r[3*c +: 3];
   endfunction

   function automatic logic [2:0] sh_of(input logic [23:0] a,
                                        input logic [2:0] c);
      logic [2:0] s;
      s = a[3*c +: 3];
      return (s > 3'h6) ? 3'h0 : s;
   endfunction

   function automatic logic brk_rng(input logic [2:0] r);
      return r == aisq_pkg::RNG_U1_5 || r == aisq_pkg::RNG_MA;
   endfunction

   function automatic logic signed [15:0] lim(input logic [2:0] r,
                                              input logic fast,
                                              input logic hi);
      logic signed [15:0] v;
      if (r == aisq_pkg::RNG_BIP10 || r > aisq_pkg::RNG_MA) begin
         v = hi ? aisq_pkg::BIP_HI_4K : aisq_pkg::BIP_LO_4K;
      end else begin
         v = hi ? aisq_pkg::UNI_HI_4K : aisq_pkg::UNI_LO_4K;
      end
      return fast ? v <<< 1 : v;
   endfunction

   function automatic logic [15:0] clamp(input logic [15:0] raw,
                                         input logic [2:0] r,
                                         input logic fast);
      logic signed [15:0] hi;
      logic signed [15:0] lo;
      hi = lim(r, fast, 1'b1);
      lo = lim(r, fast, 1'b0);
      if ($signed(raw) > hi) begin
         return hi;
      end else if ($signed(raw) < lo) begin
         return lo;
      end
      return raw;
   endfunction

   function automatic logic [3:0] next_ch(input logic [7:0] en,
                                          input logic [2:0] last);
      logic [3:0] r;
      logic [2:0] c;
      r = 4'h8;
      for (int k = 8; k >= 1; k--) begin
         c = 3'(int'(last) + k);
         if (en[c]) begin
            r = {1'b0, c};
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] bmask(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = n[8*b +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [15:0] rep(input aisq_state_t s,
                                       input logic [2:0] c);
      return (s.hold[c] && s.pk_ok[c]) ? s.peak[c] : s.val[c];
   endfunction

   // =============================================================
   // Next-state logic
   // =============================================================
   logic [9:0] widx;
   logic [3:0] nx;
   logic pop;
   logic push;
   logic [2:0] sh;
   logic [6:0] n_cur;
   logic [31:0] rdw;
   logic [31:0] w;
   logic [21:0] mean;
   logic [2:0] hc;

   assign widx = wb_adr_i[11:2];
   assign sh = sh_of(q.avg, q.ch);
   assign n_cur = 7'h01 << sh;
   assign hc = q.fifo[0][18:16];

   always_comb begin
      d = q;
      d.req = 1'b0;
      mem_we = 1'b0;
      mem_addr = {q.ch, q.wp[q.ch]};
      pop = 1'b0;
      push = adc_valid_i && q.rdy;
      nx = next_ch(q.en, q.last);
      mean = $signed(q.acc) >>> sh;
      rdw = 32'h00000000;
      w = 32'h00000000;

      // Point timer and ascending channel scan.
      if (q.tmr == 17'h00000) begin
         d.tmr = q.fast ? 17'(FAST_CYC - 1) : 17'(SLOW_CYC - 1);
         if (!nx[3]) begin
            d.req = 1'b1;
            d.req_ch = nx[2:0];
            d.last = nx[2:0];
         end
      end else begin
         d.tmr = q.tmr - 17'h00001;
      end

      for (int c = 0; c < 8; c++) begin
         if (!q.hold[c]) begin
            d.pk_ok[c] = 1'b0;
         end
      end

      // Sample processing.
      unique case (q.st)
         aisq_pkg::ST_IDLE: begin
            if (q.cnt != 2'h0) begin
               pop = 1'b1;
               d.ch = hc;
               d.smp = clamp(q.fifo[0][15:0], rng_of(q.rng, hc),
                             q.fast);
               d.brk[hc] = brk_rng(rng_of(q.rng, hc)) &&
                           $signed(q.fifo[0][15:0]) <
                           aisq_pkg::BRK_LIM;
               d.i = 7'h00;
               d.st = q.primed[hc] ? aisq_pkg::ST_WR
                                   : aisq_pkg::ST_PRIME;
            end
         end
         aisq_pkg::ST_PRIME: begin
            // The first sample fills the whole history window.
            mem_we = 1'b1;
            mem_addr = {q.ch, q.i[5:0]};
            d.i = q.i + 7'h01;
            if (q.i == 7'h3f) begin
               d.primed[q.ch] = 1'b1;
               d.st = aisq_pkg::ST_WR;
            end
         end
         aisq_pkg::ST_WR: begin
            mem_we = 1'b1;
            d.i = 7'h00;
            d.acc = 22'h000000;
            d.rd_v = 1'b0;
            d.st = aisq_pkg::ST_SUM;
         end
         aisq_pkg::ST_SUM: begin
            mem_addr = {q.ch, q.wp[q.ch] - q.i[5:0]};
            d.rd_v = q.i < n_cur;
            if (q.rd_v) begin
               d.acc = q.acc + {{6{mem_rd[15]}}, mem_rd};
            end
            if (q.i == n_cur) begin
               d.st = aisq_pkg::ST_DONE;
            end else begin
               d.i = q.i + 7'h01;
            end
         end
         aisq_pkg::ST_DONE: begin
            d.val[q.ch] = mean[15:0];
            d.wp[q.ch] = q.wp[q.ch] + 6'h01;
            if (q.hold[q.ch] && (!q.pk_ok[q.ch] ||
                $signed(mean[15:0]) > $signed(q.peak[q.ch]))) begin
               d.peak[q.ch] = mean[15:0];
            end
            d.pk_ok[q.ch] = q.hold[q.ch];
            d.st = aisq_pkg::ST_IDLE;
         end
         default: begin
            d.st = aisq_pkg::ST_IDLE;
         end
      endcase

      // Two-entry result buffer; a full buffer stalls the converter.
      if (pop) begin
         d.fifo[0] = q.fifo[1];
      end
      if (push) begin
         d.fifo[q.cnt - 2'(pop)] = {adc_ch_i, adc_data_i};
      end
      d.cnt = q.cnt + 2'(push) - 2'(pop);
      d.rdy = d.cnt != 2'h2;

      // Register read mux.
      if (widx == aisq_pkg::CYC_BASE + aisq_pkg::CYC_HOLD_IDX) begin
         rdw = {24'h000000, q.hold};
      end else if (widx >= aisq_pkg::CYC_BASE + aisq_pkg::CYC_VAL_IDX &&
                   widx < aisq_pkg::CYC_BASE + aisq_pkg::CYC_FLAG_IDX) begin
         rdw = {16'h0000, rep(q, 3'(widx - aisq_pkg::CYC_VAL_IDX))};
      end else if (widx == aisq_pkg::CYC_BASE + aisq_pkg::CYC_FLAG_IDX) begin
         rdw = {24'h000000, q.brk};
         rdw[aisq_pkg::FLAG_ALARM_BIT] = |q.brk;
      end else if (widx == aisq_pkg::CFG_BASE + aisq_pkg::CFG_EN_IDX) begin
         rdw = {24'h000000, q.en};
      end else if (widx == aisq_pkg::CFG_BASE + aisq_pkg::CFG_RNG_IDX) begin
         rdw = {8'h00, q.rng};
      end else if (widx == aisq_pkg::CFG_BASE + aisq_pkg::CFG_AVG_IDX) begin
         rdw = {8'h00, q.avg};
      end else if (widx == aisq_pkg::CFG_BASE + aisq_pkg::CFG_MODE_IDX) begin
         rdw[aisq_pkg::MODE_FAST_BIT] = q.fast;
      end

      // Wishbone: one registered ack per request, dropped next cycle.
      d.ack = 1'b0;
      if (wb_cyc_i && wb_stb_i && !q.ack) begin
         d.ack = 1'b1;
         d.dat = rdw;
         w = bmask(rdw, wb_dat_i, wb_sel_i);
         if (wb_we_i) begin
            unique case (widx)
               aisq_pkg::CYC_BASE + aisq_pkg::CYC_HOLD_IDX:
                  d.hold = w[7:0];
               aisq_pkg::CFG_BASE + aisq_pkg::CFG_EN_IDX:
                  d.en = w[7:0];
               aisq_pkg::CFG_BASE + aisq_pkg::CFG_RNG_IDX:
                  d.rng = w[23:0];
               aisq_pkg::CFG_BASE + aisq_pkg::CFG_AVG_IDX:
                  d.avg = w[23:0];
               aisq_pkg::CFG_BASE + aisq_pkg::CFG_MODE_IDX:
                  d.fast = w[aisq_pkg::MODE_FAST_BIT];
               default: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         q <= '0;
         q.en <= aisq_pkg::EN_RST;
         q.rng <= aisq_pkg::RNG_RST;
         q.avg <= aisq_pkg::AVG_RST;
         q.fast <= aisq_pkg::MODE_RST;
         q.rdy <= 1'b1;
         q.last <= 3'h7;
      end else if (ce_i) begin
         q <= d;
      end
   end

   aisq_hist_mem u_mem (
      .clk_i(clk_i),
      .ce_i(ce_i),
      .we_i(mem_we),
      .addr_i(mem_addr),
      .wdata_i(q.smp),
      .rdata_o(mem_rd)
   );

   // A stored value reaches the bus only through a registered read.
   assign wb_dat_o = q.dat;
   assign wb_ack_o = q.ack;
   assign adc_req_o = q.req;
   assign adc_ch_o = q.req_ch;
   assign adc_ready_o = q.rdy;

   // =============================================================
   // Checks
   // =============================================================
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i || !ce_i);

   sequence s_sum_end;
      q.st == aisq_pkg::ST_SUM && q.i == n_cur;
   endsequence

   chk_avg_count: assert property (s_sum_end |=>
      q.st == aisq_pkg::ST_DONE ##1 q.st == aisq_pkg::ST_IDLE)
      else $error("averaging pass did not end after n reads");

   chk_peak_hold: assert property (
      q.st == aisq_pkg::ST_DONE && q.hold[q.ch] && q.pk_ok[q.ch]
      |=> $signed(q.peak[q.ch]) >= $signed($past(q.peak[q.ch])))
      else $error("held peak decreased");

   chk_brk_set: assert property (
      q.st == aisq_pkg::ST_IDLE && q.cnt != 2'h0 &&
      brk_rng(rng_of(q.rng, hc)) &&
      $signed(q.fifo[0][15:0]) < aisq_pkg::BRK_LIM
      |=> q.brk[q.ch])
      else $error("broken line not flagged");

   chk_brk_range: assert property (
      q.st == aisq_pkg::ST_WR && !brk_rng(rng_of(q.rng, q.ch))
      |-> !q.brk[q.ch])
      else $error("break flag on a range without detection");

   chk_tmr_reload: assert property (
      q.tmr == 17'h00000 ##1 1'b1 |->
      q.tmr == ($past(q.fast) ? 17'(FAST_CYC - 1) : 17'(SLOW_CYC - 1)))
      else $error("point period reload wrong");

   chk_clamp_lim: assert property (
      q.st == aisq_pkg::ST_WR |->
      $signed(q.smp) <= lim(rng_of(q.rng, q.ch), q.fast, 1'b1) &&
      $signed(q.smp) >= lim(rng_of(q.rng, q.ch), q.fast, 1'b0))
      else $error("result outside range limits");

   chk_bip_span: assert property (
      q.st == aisq_pkg::ST_WR && !q.fast &&
      rng_of(q.rng, q.ch) == aisq_pkg::RNG_BIP10 |->
      $signed(q.smp) >= 16'shf768 && $signed(q.smp) <= 16'sh0898)
      else $error("bipolar result outside F768..0898");

   chk_bus_ack: assert property (
      wb_cyc_i && wb_stb_i && !q.ack |=> q.ack ##1 !q.ack)
      else $error("bus ack not one cycle after request");

   chk_req_enabled: assert property (
      q.req |-> q.en[q.req_ch] && $past(q.tmr) == 17'h00000)
      else $error("request for a disabled channel");

endmodule

// ### bench/aisq_adc_model.sv
`timescale 1ns/100ps
// ==========================================================
// Converter front end model
// ==========================================================
module aisq_adc_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Requests from the sequencer
   input wire logic req_i,
   input wire logic [2:0] req_ch_i,
   // Results toward the sequencer
   output logic valid_o,
   output logic [2:0] ch_o,
   output logic [15:0] data_o,
   input wire logic ready_i,
   // Bench controls
   input wire logic slow_i,
   input wire logic burst_i,
   input wire logic fix_en_i,
   input wire logic [15:0] fix_i
);
   int pend[$];
   int c;
   always @(posedge clk_i) begin
      if (rst_n_i && req_i) begin
         pend.push_back(int'(req_ch_i));
      end
   end
   // A result is held until ready is seen at an edge; idle lines
   // show the inverse of the last value so stale data never matches.
   initial begin
      valid_o = 1'b0;
      ch_o = 3'h7;
      data_o = 16'hffff;
      forever begin
         @(posedge clk_i);
         if (pend.size() > 0) begin
            c = pend.pop_front();
            if (slow_i) begin
               repeat ($urandom_range(20, 1)) @(posedge clk_i);
            end
            repeat (burst_i ? 4 : 1) begin
               valid_o <= 1'b1;
               ch_o <= c[2:0];
               data_o <= fix_en_i ? fix_i
                  : 16'($urandom_range(8000, 0) - 3000);
               do @(posedge clk_i); while (ready_i !== 1'b1);
            end
            valid_o <= 1'b0;
            ch_o <= ~ch_o;
            data_o <= ~data_o;
         end
      end
   end
endmodule

// ### bench/tb_aisq_top.sv
`timescale 1ns/100ps
module tb_aisq_top;
   localparam int SLOW = 500;
   localparam int FAST = 250;
   localparam logic [11:0] A_HOLD = 12'(aisq_pkg::CYC_HOLD_IDX * 4);
   localparam logic [11:0] A_FLAG = 12'(aisq_pkg::CYC_FLAG_IDX * 4);
   localparam logic [11:0] A_EN = 12'((aisq_pkg::CFG_BASE + 10'h000) * 4);
   localparam logic [11:0] A_RNG = A_EN + 12'h004;
   localparam logic [11:0] A_AVG = A_EN + 12'h008;
   localparam logic [11:0] A_MODE =
      12'((aisq_pkg::CFG_BASE + aisq_pkg::CFG_MODE_IDX) * 4);
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [11:0] wb_adr_i = 12'h000;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o;
   logic wb_ack_o, adc_req_o, adc_valid_i, adc_ready_o;
   logic [2:0] adc_ch_o, adc_ch_i;
   logic [15:0] adc_data_i, fix_v = 16'h0000;
   logic slow = 1'b0, burst = 1'b0, fix_en = 1'b0, fast_sh = 1'b0, ce = 1'b1;
   logic [7:0] en_sh = 8'h00, hold_sh = 8'h00, brk = 8'h00;
   logic [7:0] have = 8'h00, pk_ok = 8'h00;
   logic signed [15:0] hist [8][$];
   logic signed [15:0] avg_v [8] = '{default: 16'sh0000};
   logic signed [15:0] peak [8], prev_e;
   logic [15:0] cor [8] = '{16'h7fff, 16'h8000, 16'h0898, 16'h0899,
      16'hf767, 16'hfe0b, 16'hfe0c, 16'h1005};
   int n_mismatch = 0, total_checks = 0;
   int last_ch = 7, gap = 0, n_acc = 0, acc_ch;
   bit gap_ok = 0, saw_full = 0;

   always #5 clk_i = ~clk_i;

   aisq_top #(.SLOW_CYC(SLOW), .FAST_CYC(FAST)) u_dut (
      .clk_i(clk_i), .ce_i(ce), .rst_n_i(rst_n_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .adc_req_o(adc_req_o), .adc_ch_o(adc_ch_o),
      .adc_valid_i(adc_valid_i), .adc_ch_i(adc_ch_i),
      .adc_data_i(adc_data_i), .adc_ready_o(adc_ready_o));

   aisq_adc_model u_adc (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(adc_req_o),
      .req_ch_i(adc_ch_o), .valid_o(adc_valid_i), .ch_o(adc_ch_i),
      .data_o(adc_data_i), .ready_i(adc_ready_o), .slow_i(slow),
      .burst_i(burst), .fix_en_i(fix_en), .fix_i(fix_v));

   // ==========================================================
   // Expectations
   // ==========================================================
   // Channel c uses range code c and averaging code c.
   function automatic logic signed [15:0] clampv(logic signed [15:0] r,
         int c);
      logic signed [15:0] hi, lo;
      hi = (c >= 1 && c <= 4) ? aisq_pkg::UNI_HI_4K : aisq_pkg::BIP_HI_4K;
      lo = (c >= 1 && c <= 4) ? aisq_pkg::UNI_LO_4K : aisq_pkg::BIP_LO_4K;
      if (fast_sh) begin
         hi = hi <<< 1;
         lo = lo <<< 1;
      end
      return (r > hi) ? hi : (r < lo) ? lo : r;
   endfunction
   function automatic logic [2:0] nxt(int l, logic [7:0] m);
      for (int i = 1; i <= 8; i++) begin
         if (m[(l + i) % 8]) return 3'((l + i) % 8);
      end
      return 3'(l);
   endfunction
   function automatic logic signed [15:0] mean(int c);
      int a = (c == 7) ? 0 : c;
      int s = 0;
      for (int i = 0; i < (1 << a); i++) s += hist[c][i];
      return 16'(s >>> a);
   endfunction
   function automatic logic [15:0] rep(int c);
      return (hold_sh[c] && pk_ok[c]) ? peak[c] : avg_v[c];
   endfunction
   function automatic logic [11:0] av(int c);
      return 12'((aisq_pkg::CYC_BASE + aisq_pkg::CYC_VAL_IDX + c) * 4);
   endfunction

   // ==========================================================
   // Checks and bus tasks
   // ==========================================================
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wb(logic [11:0] a, logic w, logic [31:0] d,
         logic [3:0] s, output logic [31:0] q);
      int k = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_adr_i <= a;
      wb_we_i <= w;
      wb_sel_i <= s;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 20);
      if (k >= 20) chk("bus ack", 32'h1, 32'h0);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(logic [11:0] a, logic [31:0] d);
      logic [31:0] q;
      wb(a, 1'b1, d, 4'hf, q);
   endtask
   task automatic rd(logic [11:0] a, logic [31:0] e, string nm);
      logic [31:0] q;
      wb(a, 1'b0, 32'h00000000, 4'hf, q);
      chk(nm, e, q);
   endtask
   task automatic chk_all();
      for (int c = 0; c < 8; c++) begin
         if (have[c]) rd(av(c), {16'h0000, rep(c)}, "value");
      end
      rd(A_FLAG, {16'h0000, |brk, 7'h00, brk}, "flags");
   endtask
   task automatic quiet();
      int k = 0;
      while (adc_req_o !== 1'b1 && k < 2000) begin
         @(posedge clk_i);
         k++;
      end
      repeat (170) @(posedge clk_i);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // ==========================================================
   // Monitor of the converter link
   // ==========================================================
   always @(posedge clk_i) begin
      logic signed [15:0] v;
      if (rst_n_i) begin
         if (ce === 1'b1) gap++;
         if (adc_ready_o === 1'b0) saw_full = 1;
         if (adc_req_o === 1'b1) begin
            chk("request channel", nxt(last_ch, en_sh), adc_ch_o);
            if (gap_ok) chk("spacing", fast_sh ? FAST : SLOW, gap);
            last_ch = adc_ch_o;
            gap = 0;
            gap_ok = 1;
         end
         if (adc_valid_i === 1'b1 && adc_ready_o === 1'b1) begin
            acc_ch = adc_ch_i;
            prev_e = rep(acc_ch);
            v = clampv(adc_data_i, acc_ch);
            if (!have[acc_ch]) repeat (64) hist[acc_ch].push_front(v);
            hist[acc_ch].push_front(v);
            void'(hist[acc_ch].pop_back());
            have[acc_ch] = 1'b1;
            brk[acc_ch] = (acc_ch == 2 || acc_ch == 4)
               && ($signed(adc_data_i) < aisq_pkg::BRK_LIM);
            v = mean(acc_ch);
            avg_v[acc_ch] = v;
            if (hold_sh[acc_ch] && (!pk_ok[acc_ch] || v > peak[acc_ch])) begin
               peak[acc_ch] = v;
            end
            pk_ok[acc_ch] = hold_sh[acc_ch];
            n_acc++;
         end
      end
   end

   initial begin
      repeat (40000) @(posedge clk_i);
      n_mismatch++;
      wrap_up();
   end

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      int k;
      logic [31:0] q;
      void'($urandom(32'h958d));
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      chk("ready", 32'h1, adc_ready_o);
      rd(A_EN, 32'(aisq_pkg::EN_RST), "enable");
      rd(A_RNG, 32'(aisq_pkg::RNG_RST), "range");
      rd(A_AVG, 32'(aisq_pkg::AVG_RST), "average");
      rd(A_MODE, 32'(aisq_pkg::MODE_RST), "mode");
      wr(12'hffc, 32'hffffffff);
      rd(12'hffc, 32'h00000000, "unmapped");
      wr(A_RNG, 32'h00fac688);
      wr(A_AVG, 32'h00fac688);
      slow <= 1'b1;
      en_sh = 8'h25;
      wr(A_EN, 32'h00000025);
      for (int i = 0; i < 24; i++) begin
         fix_en <= 1'b1;
         fix_v <= (i < 16) ? cor[i % 8]
            : 16'($urandom_range(8000, 0) - 3000);
         quiet();
         chk_all();
         // A frozen spell must stretch the point period by its length.
         if (i == 5) begin
            ce <= 1'b0;
            repeat (40) @(posedge clk_i);
            ce <= 1'b1;
         end
         if (i == 10 || i == 18) begin
            hold_sh = (i == 10) ? 8'h05 : 8'h00;
            pk_ok = 8'h00;
            wr(A_HOLD, {24'h000000, hold_sh});
         end
         if (i == 12) wr(av(0), 32'hffffffff);
         if (i == 13) begin
            wb(A_EN, 1'b1, 32'hffffffff, 4'h2, q);
            rd(A_EN, 32'h00000025, "enable merge");
         end
      end
      en_sh = 8'hff;
      fast_sh = 1'b1;
      gap_ok = 0;
      wr(A_MODE, 32'h00000001);
      wr(A_EN, 32'h000000ff);
      for (int i = 0; i < 16; i++) begin
         fix_en <= 1'b1;
         fix_v <= (i < 8) ? cor[i % 8]
            : 16'($urandom_range(8000, 0) - 3000);
         slow <= (i % 2 == 0);
         quiet();
         chk_all();
         if (i == 10) begin
            k = n_acc;
            for (int j = 0; j < 500 && n_acc == k; j++) @(posedge clk_i);
            rd(av(acc_ch), {16'h0000, prev_e}, "early value");
         end
      end
      fix_en <= 1'b0;
      burst <= 1'b1;
      repeat (2) quiet();
      burst <= 1'b0;
      repeat (3) quiet();
      chk("buffer full seen", 32'h1, {31'h0, saw_full});
      chk("ready drained", 32'h1, adc_ready_o);
      chk_all();
      wrap_up();
   end
endmodule
